// >>> verilog/adcseq_pkg.sv
// Purpose: constants and types for the conversion sequencer
// Assumes: 8-bit register port, one register per index
// Notes: register indices chosen locally
package adcseq_pkg;
   localparam logic [2:0] ADDR_CTRL_A = 3'h0;
   localparam logic [2:0] ADDR_CTRL_B = 3'h1;
   localparam logic [2:0] ADDR_RES_LO = 3'h2;
   localparam logic [2:0] ADDR_RES_HI = 3'h3;
   localparam logic [2:0] ADDR_MUX = 3'h4;
   // control a fields
   localparam int BIT_EN = 7;
   localparam int BIT_START = 6;
   localparam int BIT_AUTO = 5;
   localparam int BIT_DONE = 4;
   localparam int BIT_IRQ_EN = 3;
   // mux register fields
   localparam int BIT_LEFT = 5;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] CTRL_B_MASK = 8'h07;
   localparam logic [2:0] TRIG_FREE = 3'h0;
   localparam logic [4:0] FIRST_CYCLES = 5'h19;
   localparam logic [4:0] NORMAL_CYCLES = 5'h0d;
   localparam int RESULT_W = 10;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } adcseq_bus_t;
endpackage : adcseq_pkg

// >>> verilog/adcseq_prescaler.sv
// Purpose: converter clock tick from the system clock
// Assumes: runs only while enabled
// Notes: one-cycle tick per converter clock period
`timescale 1ns/10ps
`default_nettype none
module adcseq_prescaler
   import adcseq_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic run,
   input wire logic [2:0] sel,
   output logic tick
);
   logic [6:0] cnt;
   logic [6:0] last;

   always_comb
   begin
      case (sel)
         3'h0, 3'h1: last = 7'h01;
         3'h2: last = 7'h03;
         3'h3: last = 7'h07;
         3'h4: last = 7'h0f;
         3'h5: last = 7'h1f;
         3'h6: last = 7'h3f;
         default: last = 7'h7f;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt <= 7'h00;
         tick <= 1'b0;
      end
      else if (!run)
      begin
         cnt <= 7'h00;
         tick <= 1'b0;
      end
      else
      begin
         tick <= ((cnt & last) == last);
         cnt <= cnt + 7'h01;
      end
   end
endmodule : adcseq_prescaler
`default_nettype wire

// >>> verilog/adcseq_top.sv
// Purpose: control for a 10-bit successive-approximation converter
// Assumes: 8-bit register port, strobes one cycle, read data next cycle
// Notes: trigger sources may be asynchronous pulses or levels
// Contract
// - enable powers converter; clearing it aborts conversion in progress
// - single mode: each start write converts; free running continues itself
// - first conversion after enable takes 25 clocks, later ones 13
// - start bit reads one while busy; writing zero does nothing
// - auto trigger starts conversion on rising edge of selected source
// - done flag set when conversion finishes and result updated
// - done flag cleared by interrupt vector or by writing one
// - interrupt requested only when flag, enable and global enable set
// - converter clock is system clock divided per prescaler code
// - low byte read locks result updates until high byte read
// - right or left alignment of 10-bit result, unused bits zero
// - trigger select ignored while auto trigger disabled
// - switching to a set source gives rising edge and starts conversion
// - selecting free running itself never triggers
// - trigger codes: free, comparator, ext0, t0 cmp, t0 ovf, t1 cmpb, t1 ovf, t1 cap
// - reference and channel changes apply after conversion completes
// - alignment change applies immediately to presented result
`timescale 1ns/10ps
`default_nettype none
module adcseq_top
   import adcseq_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic [RESULT_W-1:0] CORE_RESULT,
   input wire logic [6:0] TRIG_SRC,
   input wire logic GLOBAL_IRQ_EN,
   input wire logic IRQ_ACK,
   output logic IRQ,
   output logic CORE_POWER,
   output logic CORE_CLK_EN,
   output logic CORE_SAMPLE,
   output logic [1:0] CORE_REF,
   output logic [4:0] CORE_CHANNEL
);
   typedef enum {ST_IDLE, ST_CONV} adcseq_state_t;
   adcseq_state_t state;
   adcseq_bus_t bus;
   logic [7:0] ctrl_a;
   logic [7:0] ctrl_b;
   logic [7:0] mux_reg;
   logic done;
   logic first;
   logic [4:0] cyc;
   logic [RESULT_W-1:0] result;
   logic locked;
   logic tick;
   logic [6:0] trig_s1;
   logic [6:0] trig_s2;
   logic trig_sel;
   logic trig_prev;
   logic trig_rise;
   logic wr_a;
   logic start_req;
   logic finish;
   logic [7:0] res_lo;
   logic [7:0] res_hi;

   assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
   assign wr_a = bus.wr && bus.addr[2:0] == ADDR_CTRL_A && bus.addr[7:3] == 5'h00;

   // trigger inputs may be asynchronous pulses
   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         trig_s1 <= 7'h00;
         trig_s2 <= 7'h00;
      end
      else
      begin
         trig_s1 <= TRIG_SRC;
         trig_s2 <= trig_s1;
      end
   end

   // free running restarts in the sequencer, so code 0 never edges
   always_comb
   begin
      case (ctrl_b[2:0])
         TRIG_FREE: trig_sel = 1'b0;
         3'h1: trig_sel = trig_s2[0];
         3'h2: trig_sel = trig_s2[1];
         3'h3: trig_sel = trig_s2[2];
         3'h4: trig_sel = trig_s2[3];
         3'h5: trig_sel = trig_s2[4];
         3'h6: trig_sel = trig_s2[5];
         default: trig_sel = trig_s2[6];
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         trig_prev <= 1'b0;
      else
         trig_prev <= trig_sel;
   end

   // a switch onto a source that is already set counts as an edge
   assign trig_rise = ctrl_a[BIT_AUTO] && trig_sel && !trig_prev;

   assign start_req = (wr_a && bus.wdata[BIT_START] && bus.wdata[BIT_EN])
      || (ctrl_a[BIT_EN] && trig_rise);
   assign finish = state == ST_CONV && tick && cyc == 5'h01;

   // control a
   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         ctrl_a <= RESET_BYTE;
      else if (wr_a)
         ctrl_a <= bus.wdata;
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         ctrl_b <= RESET_BYTE;
      else if (bus.wr && bus.addr == {5'h00, ADDR_CTRL_B})
         ctrl_b <= bus.wdata & CTRL_B_MASK;
   end

   // reference, alignment and channel
   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         mux_reg <= RESET_BYTE;
      else if (bus.wr && bus.addr == {5'h00, ADDR_MUX})
         mux_reg <= bus.wdata;
   end

   // done flag: set wins over clear
   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         done <= 1'b0;
      else if (finish && !locked)
         done <= 1'b1;
      else if (IRQ_ACK || (wr_a && bus.wdata[BIT_DONE]))
         done <= 1'b0;
   end

   // sequencer
   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         state <= ST_IDLE;
         cyc <= 5'h00;
         first <= 1'b1;
      end
      else if (!(wr_a ? bus.wdata[BIT_EN] : ctrl_a[BIT_EN]))
      begin
         state <= ST_IDLE;
         first <= 1'b1;
         cyc <= 5'h00;
      end
      else if (state == ST_IDLE && start_req)
      begin
         state <= ST_CONV;
         cyc <= first ? FIRST_CYCLES : NORMAL_CYCLES;
         first <= 1'b0;
      end
      else if (state == ST_CONV && tick)
      begin
         if (cyc == 5'h01)
         begin
            // free running restarts directly
            if (ctrl_a[BIT_AUTO] && ctrl_b[2:0] == TRIG_FREE)
               cyc <= NORMAL_CYCLES;
            else
               state <= ST_IDLE;
         end
         else
            cyc <= cyc - 5'h01;
      end
   end

   // result latch with read lock
   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         result <= '0;
      else if (finish && !locked)
         result <= CORE_RESULT;
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         locked <= 1'b0;
      else if (bus.rd && bus.addr == {5'h00, ADDR_RES_LO})
         locked <= 1'b1;
      else if (bus.rd && bus.addr == {5'h00, ADDR_RES_HI})
         locked <= 1'b0;
   end

   // selections reach the core only between conversions
   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         CORE_REF <= 2'h0;
         CORE_CHANNEL <= 5'h00;
      end
      else if (state == ST_IDLE || finish)
      begin
         CORE_REF <= mux_reg[7:6];
         CORE_CHANNEL <= mux_reg[4:0];
      end
   end

   // presentation follows alignment immediately
   always_comb
   begin
      if (mux_reg[BIT_LEFT])
      begin
         res_hi = result[9:2];
         res_lo = {result[1:0], 6'h00};
      end
      else
      begin
         res_hi = {6'h00, result[9:8]};
         res_lo = result[7:0];
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         RDATA <= 8'h00;
      else if (!bus.rd)
         RDATA <= 8'h00;
      else if (bus.addr == {5'h00, ADDR_CTRL_A})
         RDATA <= {ctrl_a[BIT_EN], state == ST_CONV, ctrl_a[BIT_AUTO], done,
            ctrl_a[3:0]};
      else if (bus.addr == {5'h00, ADDR_CTRL_B})
         RDATA <= ctrl_b;
      else if (bus.addr == {5'h00, ADDR_RES_LO})
         RDATA <= res_lo;
      else if (bus.addr == {5'h00, ADDR_RES_HI})
         RDATA <= res_hi;
      else if (bus.addr == {5'h00, ADDR_MUX})
         RDATA <= mux_reg;
      else
         RDATA <= 8'h00;
   end

   // outputs, each from its own flop
   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         IRQ <= 1'b0;
      else
         IRQ <= done && ctrl_a[BIT_IRQ_EN] && GLOBAL_IRQ_EN;
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         CORE_POWER <= 1'b0;
      else
         CORE_POWER <= ctrl_a[BIT_EN];
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         CORE_CLK_EN <= 1'b0;
      else
         CORE_CLK_EN <= ctrl_a[BIT_EN] && state == ST_CONV && tick;
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         CORE_SAMPLE <= 1'b0;
      else
         CORE_SAMPLE <= finish;
   end

   adcseq_prescaler u_presc (
      .clk(CORE_CLK),
      .reset_n(RESET_N),
      .run(ctrl_a[BIT_EN]),
      .sel(ctrl_a[2:0]),
      .tick(tick)
   );
endmodule : adcseq_top
`default_nettype wire

// >>> tb/adcseq_chk.sv
// Purpose: port assertions for the sequencer
// Assumes: bound into adcseq_top
// Notes: all outputs registered
`timescale 1ns/10ps
`default_nettype none
module adcseq_chk
   import adcseq_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic GLOBAL_IRQ_EN,
   input wire logic IRQ_ACK,
   input wire logic IRQ,
   input wire logic CORE_POWER,
   input wire logic CORE_CLK_EN,
   input wire logic CORE_SAMPLE
);
   logic left;
   wire logic wr_off = WR && ADDR == 8'h00 && !WDATA[BIT_EN];
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   // alignment as software last wrote it
   always_ff @(posedge CORE_CLK or negedge RESET_N)
      if (!RESET_N)
         left <= 1'b0;
      else if (WR && ADDR == 8'h04)
         left <= WDATA[BIT_LEFT];
   property p_glob; $rose(IRQ) |-> $past(GLOBAL_IRQ_EN); endproperty
   property p_ack; IRQ_ACK |-> ##2 !IRQ; endproperty
   property p_div; CORE_CLK_EN |=> !CORE_CLK_EN; endproperty
   property p_len; CORE_SAMPLE |=> !CORE_SAMPLE [*8]; endproperty
   property p_rsv; RD && ADDR == 8'h01 |=> RDATA[7:3] == 5'h00; endproperty
   property p_off; wr_off ##1 !WR [*2] |=> !CORE_POWER && !CORE_CLK_EN; endproperty
   property p_right; RD && ADDR == 8'h03 && !left |=> RDATA[7:2] == 6'h00; endproperty
   property p_left; RD && ADDR == 8'h02 && left |=> RDATA[5:0] == 6'h00; endproperty
   a_glob: assert property (p_glob) else $error("irq without global enable");
   a_ack: assert property (p_ack) else $error("irq kept after ack");
   a_div: assert property (p_div) else $error("converter clock too fast");
   a_len: assert property (p_len) else $error("conversion too short");
   a_rsv: assert property (p_rsv) else $error("control b spare bits set");
   a_off: assert property (p_off) else $error("converter still running");
   a_right: assert property (p_right) else $error("high byte spare bits set");
   a_left: assert property (p_left) else $error("low byte spare bits set");
   c_irq: cover property (IRQ);
   c_left: cover property (RD && ADDR == 8'h02 && left);
   c_off: cover property (wr_off);
endmodule : adcseq_chk
bind adcseq_top adcseq_chk chk (.CORE_CLK, .RESET_N, .ADDR, .WDATA, .WR, .RD, .RDATA,
   .GLOBAL_IRQ_EN, .IRQ_ACK, .IRQ, .CORE_POWER, .CORE_CLK_EN, .CORE_SAMPLE);
`default_nettype wire

// >>> tb/adcseq_core_model.sv
// Purpose: analog core stand-in
// Assumes: one tick per converter clock
// Notes: counts ticks and spacing per conversion
`timescale 1ns/10ps
`default_nettype none
module adcseq_core_model
   import adcseq_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic power,
   input wire logic clk_en,
   input wire logic sample,
   input wire logic [RESULT_W-1:0] value,
   output logic [RESULT_W-1:0] result,
   output logic [7:0] ticks,
   output logic [7:0] gap
);
   logic [7:0] since;
   logic sample_d;
   // unpowered output is garbage, toggled each cycle
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
         result <= '0;
      else
         result <= power ? value : ~result;
   // the last tick of a conversion comes with the sample pulse
   always_ff @(posedge clk)
   begin
      sample_d <= sample;
      since <= (since == 8'hff) ? since : since + 8'h01;
      if (clk_en) since <= 8'h01;
      if (clk_en) gap <= since;
      if (clk_en) ticks <= ticks + 8'h01;
      if (!power) ticks <= 8'h00;
      else if (sample_d) ticks <= {7'h00, clk_en};
   end
endmodule : adcseq_core_model
`default_nettype wire

// >>> tb/adc_conversion_sequencer_tb.sv
// Purpose: self-checking bench for the sequencer
// Assumes: core model and bound checker
// Notes: expected reads and conversions queued
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_sequencer_tb
   import adcseq_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, gie = 1'b0, ack = 1'b0;
   logic irq, pwr, cken, smp, rd_d = 1'b0;
   logic smp_d = 1'b0;
   logic [1:0] ref_sel;
   logic [4:0] chan;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, ticks, gap;
   logic [6:0] trig = 7'h00;
   logic [9:0] val = 10'h000, old, core_res;
   logic [7:0] rq[$], cq[$];
   int num_errors = 0, n_compared = 0, seed = 32'hf756bf92;
   always #50 clk = ~clk;
   adcseq_top dut (.CORE_CLK(clk), .RESET_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .CORE_RESULT(core_res), .TRIG_SRC(trig), .GLOBAL_IRQ_EN(gie),
      .IRQ_ACK(ack), .IRQ(irq), .CORE_POWER(pwr), .CORE_CLK_EN(cken), .CORE_SAMPLE(smp),
      .CORE_REF(ref_sel), .CORE_CHANNEL(chan));
   adcseq_core_model core (.clk(clk), .reset_n(rst_n), .power(pwr), .clk_en(cken),
      .sample(smp), .value(val), .result(core_res), .ticks(ticks), .gap(gap));
   task summarize();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task wr8(input logic [2:0] a, input logic [7:0] d);
      wr <= 1'b1;
      addr <= {5'h00, a};
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr8
   task rd8(input logic [2:0] a, input logic [7:0] e);
      rq.push_back(e);
      rd <= 1'b1;
      addr <= {5'h00, a};
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask : rd8
   task chk_res(input logic [9:0] v, input logic left);
      rd8(ADDR_RES_LO, left ? {v[1:0], 6'h00} : v[7:0]);
      rd8(ADDR_RES_HI, left ? v[9:2] : {6'h00, v[9:8]});
   endtask : chk_res
   // note ticks and spacing, then wait for the sample pulse
   task conv(input logic [7:0] n, input logic [7:0] g);
      cq.push_back(n);
      cq.push_back(g);
      repeat (4000)
      begin
         @(posedge clk);
         if (smp === 1'b1) return;
      end
      chk("sample", 8'h01, 8'h00);
      summarize();
   endtask : conv
   always @(posedge clk)
   begin
      rd_d <= rd;
      smp_d <= smp;
      if (rd_d) chk("rdata", rq.pop_front(), rdata);
      if (smp_d === 1'b1) chk("ticks", cq.pop_front(), ticks);
      if (smp_d === 1'b1) chk("gap", cq.pop_front(), gap);
   end
   initial
   begin
      val <= 10'($random(seed));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      gie <= 1'b1;
      @(posedge clk);
      rd8(ADDR_CTRL_A, 8'h00);
      chk_res(10'h000, 1'b0);
      $display("test reset values done");
      wr8(ADDR_CTRL_A, 8'hc0);
      conv(8'h19, 8'h02);
      rd8(ADDR_CTRL_A, 8'h90);
      chk_res(val, 1'b0);
      wr8(ADDR_MUX, 8'h20);
      chk_res(val, 1'b1);
      $display("test first conversion done");
      for (int p = 0; p < 8; p++)
      begin
         wr8(ADDR_CTRL_A, 8'hd8 | 8'(p));
         conv(8'h0d, (p < 2) ? 8'h02 : 8'h01 << p);
      end
      rd8(ADDR_CTRL_A, 8'h9f);
      chk("irq", 8'h01, {7'h00, irq});
      gie <= 1'b0;
      repeat (2) @(posedge clk);
      chk("irq", 8'h00, {7'h00, irq});
      gie <= 1'b1;
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      @(posedge clk);
      rd8(ADDR_CTRL_A, 8'h8f);
      chk("irq", 8'h00, {7'h00, irq});
      $display("test prescaler and irq done");
      rd8(ADDR_RES_LO, {val[1:0], 6'h00});
      old = val;
      val <= ~val;
      wr8(ADDR_CTRL_A, 8'hd8);
      wr8(ADDR_MUX, 8'h6b);
      chk("ref chan", 8'h00, {1'b0, ref_sel, chan});
      conv(8'h0d, 8'h02);
      chk("ref chan", 8'h2b, {1'b0, ref_sel, chan});
      rd8(ADDR_RES_HI, old[9:2]);
      $display("test result lock done");
      wr8(ADDR_CTRL_B, 8'h01);
      wr8(ADDR_CTRL_A, 8'hb0);
      for (int c = 1; c < 8; c++)
      begin
         wr8(ADDR_CTRL_B, 8'(c));
         trig[c-1] <= 1'b1;
         conv(8'h0d, 8'h02);
         trig[c-1] <= 1'b0;
      end
      chk_res(val, 1'b1);
      $display("test auto trigger done");
      rd8(ADDR_CTRL_B, 8'h07);
      wr8(ADDR_CTRL_B, 8'h00);
      rd8(ADDR_CTRL_A, 8'hb0);
      wr8(ADDR_CTRL_A, 8'hf0);
      conv(8'h0d, 8'h02);
      conv(8'h0d, 8'h02);
      $display("test free running done");
      wr8(ADDR_CTRL_A, 8'h00);
      rd8(ADDR_CTRL_A, 8'h10);
      rd8(3'h5, 8'h00);
      rd8(ADDR_CTRL_B, 8'h00);
      @(posedge clk);
      $display("test shutdown done");
      summarize();
   end
endmodule : adc_conversion_sequencer_tb
`default_nettype wire
